/* inc/sah_cfg.svh */
// timing figures for the sampling converter host port
// assumes a 250 MHz system clock; counts derived from printed times
`ifndef SAH_CFG_SVH
`define SAH_CFG_SVH

`define SAH_CLK_PS      4000
`define SAH_T_WR_NS     250
`define SAH_T_FAST_NS   250
`define SAH_T_GAP_NS    350
`define SAH_T_ACC_NS    100
`define SAH_CEIL_CYC(ns) (((ns) * 1000 + `SAH_CLK_PS - 1) / `SAH_CLK_PS)
`define SAH_WR_CYC      `SAH_CEIL_CYC(`SAH_T_WR_NS)
`define SAH_FAST_CYC    `SAH_CEIL_CYC(`SAH_T_FAST_NS)
`define SAH_GAP_CYC     `SAH_CEIL_CYC(`SAH_T_GAP_NS)
`define SAH_ACC_CYC     `SAH_CEIL_CYC(`SAH_T_ACC_NS)
`define SAH_MODE_RDSTART 1'b0
`define SAH_MODE_SPLIT   1'b1
`define SAH_RES_W       8

`endif

/* inc/sah_pkg.sv */
// types for the sampling converter host port
// timing and widths live in sah_cfg.svh
package sah_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SPLIT_WR,
    ST_SPLIT_WAIT,
    ST_SPLIT_RD,
    ST_RS_WAIT
  } sah_state_t;
endpackage

/* src/sah_host.sv */
// host controller driving an 8-bit sampling converter over its bus pins
// assumes pins are synchronous to sys_clk and an external pull-up on the
// shared strobe/ready pin; the converter is a separate chip
//
// Contract
// - read-start: hold select and read low until the result appears.
// - fast split read: read may fall 250 ns after write rises.
// - normal split read waits for done low before reading.
// - read-start: stretch read over conversion using ready as wait.
// - split: write starts, separate later read collects, no waits.
// - issue conversion starts from a precise timer for equal spacing.
// - leave at least 350 ns from conversion end to next sample edge.
// - split: hold write strobe low at least 250 ns.
`include "sah_cfg.svh"
`timescale 1ns/1ps

module sah_host #(
  parameter logic [15:0] PERIOD_CYC = 16'h00FA
) (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   start_req,
  input  wire logic                   auto_en,
  input  wire logic                   split_sel,
  input  wire logic                   fast_sel,
  output logic                        conv_cs_n,
  output logic                        conv_rd_n,
  output logic                        strobe_out,
  output logic                        strobe_oe_n,
  input  wire logic                   strobe_in,
  input  wire logic                   done_n,
  input  wire logic [`SAH_RES_W-1:0]  result_bus,
  output logic                        mode_pin,
  output logic [`SAH_RES_W-1:0]       result,
  output logic                        result_valid,
  output logic                        busy
);

  localparam logic [7:0] WR_CYC   = 8'(`SAH_WR_CYC);
  localparam logic [7:0] FAST_CYC = 8'(`SAH_FAST_CYC);
  localparam logic [7:0] GAP_CYC  = 8'(`SAH_GAP_CYC);
  localparam logic [7:0] ACC_CYC  = 8'(`SAH_ACC_CYC);

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  sah_pkg::sah_state_t state_q, state_d;
  logic [7:0]            cnt_q, cnt_d;
  logic [7:0]            gap_q, gap_d;
  logic [15:0]           tick_q;
  logic                  pend_q, fast_q, fast_d;
  logic                  cs_d, rd_d, wr_d, mode_d;
  logic                  cap, go, tick, gap_ok, idle;
  logic [7:0]            wr_low_q, since_wr_q;

  // free-running sample timer keeps start spacing exact
  assign tick   = auto_en && (tick_q == PERIOD_CYC - 16'h0001);
  assign idle   = (state_q == sah_pkg::ST_IDLE);
  assign gap_ok = (gap_q >= GAP_CYC);
  assign go     = pend_q && idle && gap_ok;

  always_comb begin
    state_d = state_q;
    cnt_d   = sat_inc(cnt_q);
    cs_d    = conv_cs_n;
    rd_d    = conv_rd_n;
    wr_d    = strobe_out;
    mode_d  = mode_pin;
    fast_d  = fast_q;
    cap     = 1'b0;
    case (state_q)
      sah_pkg::ST_IDLE: begin
        mode_d = split_sel ? `SAH_MODE_SPLIT : `SAH_MODE_RDSTART;
        wr_d   = 1'b1;
        if (go) begin
          cnt_d  = 8'h00;
          cs_d   = 1'b0;
          fast_d = fast_sel;
          if (mode_d == `SAH_MODE_SPLIT) begin
            wr_d    = 1'b0;
            state_d = sah_pkg::ST_SPLIT_WR;
          end else begin
            rd_d    = 1'b0;
            state_d = sah_pkg::ST_RS_WAIT;
          end
        end
      end
      sah_pkg::ST_SPLIT_WR: begin
        if (cnt_q == WR_CYC - 8'h01) begin
          wr_d    = 1'b1;
          cnt_d   = 8'h00;
          state_d = sah_pkg::ST_SPLIT_WAIT;
        end
      end
      sah_pkg::ST_SPLIT_WAIT: begin
        if (fast_q ? (cnt_q == FAST_CYC - 8'h01) : !done_n) begin
          rd_d    = 1'b0;
          cnt_d   = 8'h00;
          state_d = sah_pkg::ST_SPLIT_RD;
        end
      end
      sah_pkg::ST_SPLIT_RD: begin
        // outputs need access time after the read strobe falls
        if (cnt_q == ACC_CYC - 8'h01) begin
          cap     = 1'b1;
          state_d = sah_pkg::ST_IDLE;
        end
      end
      sah_pkg::ST_RS_WAIT: begin
        // ready released and done low marks a finished conversion
        if (strobe_in && !done_n) begin
          cap     = 1'b1;
          state_d = sah_pkg::ST_IDLE;
        end
      end
      default: state_d = sah_pkg::ST_IDLE;
    endcase
    if (cap) begin
      cs_d = 1'b1;
      rd_d = 1'b1;
    end
  end

  // end of conversion restarts the settling gap
  assign gap_d = cap ? 8'h00 : sat_inc(gap_q);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= sah_pkg::ST_IDLE;
      cnt_q   <= 8'h00;
      gap_q   <= 8'hFF;
      tick_q  <= 16'h0000;
      pend_q  <= 1'b0;
      fast_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      gap_q   <= gap_d;
      // held clear while disabled: first request one period after enable
      tick_q  <= (tick || !auto_en) ? 16'h0000 : tick_q + 16'h0001;
      // a new request in the accepting cycle is kept, not lost
      pend_q  <= start_req || tick || (pend_q && !go);
      fast_q  <= fast_d;
    end
  end

  // shared pin is only driven as write strobe in split mode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      conv_cs_n    <= 1'b1;
      conv_rd_n    <= 1'b1;
      strobe_out   <= 1'b1;
      strobe_oe_n  <= 1'b1;
      mode_pin     <= `SAH_MODE_RDSTART;
      busy         <= 1'b0;
    end else begin
      conv_cs_n    <= cs_d;
      conv_rd_n    <= rd_d;
      strobe_out   <= wr_d;
      strobe_oe_n  <= (mode_d != `SAH_MODE_SPLIT);
      mode_pin     <= mode_d;
      busy         <= (state_d != sah_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      result       <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= cap;
      if (cap) begin
        result <= result_bus;
      end
    end
  end

  // helper counters watched only by the checks below
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_low_q   <= 8'h00;
      since_wr_q <= 8'h00;
    end else begin
      wr_low_q   <= strobe_out ? 8'h00 : sat_inc(wr_low_q);
      since_wr_q <= strobe_out ? sat_inc(since_wr_q) : 8'h00;
    end
  end

  sequence sample_edge_s;
    (mode_pin && !strobe_oe_n && $fell(strobe_out)) ||
    (!mode_pin && $fell(conv_rd_n));
  endsequence

  wr_low_width_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $rose(strobe_out) |-> wr_low_q >= WR_CYC)
    else $error("write strobe low too short");

  sample_gap_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    sample_edge_s |-> $past(gap_q) >= GAP_CYC)
    else $error("sample edge too soon after conversion end");

  rs_read_hold_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (state_q == sah_pkg::ST_RS_WAIT) && (done_n || !strobe_in)
    |=> !conv_rd_n && !conv_cs_n)
    else $error("read released before result");

  rs_no_drive_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !mode_pin |-> strobe_oe_n)
    else $error("ready pin driven in read-start mode");

  normal_read_wait_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $fell(conv_rd_n) && mode_pin && !fast_q |-> !$past(done_n))
    else $error("read started before done");

  fast_read_delay_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $fell(conv_rd_n) && mode_pin && fast_q |-> since_wr_q >= FAST_CYC)
    else $error("fast read too early");

  split_write_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $fell(strobe_out) |-> !conv_cs_n && conv_rd_n && mode_pin
    ##1 conv_rd_n [*8])
    else $error("write start malformed");

  result_take_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    result_valid |-> $past(!conv_rd_n && !conv_cs_n)
    && conv_rd_n && conv_cs_n && result == $past(result_bus))
    else $error("result not taken during read");

endmodule

/* dv/sah_dev_model.sv */
// behavioural converter at the far side of the host port
// assumes the bench resolves the shared pin and the result bus
`timescale 1ns/1ps
module sah_dev_model #(
  parameter int T_INT = 95,
  parameter int T_RS  = 175
) (
  input  wire logic       sys_clk,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       pin,
  input  wire logic       mode,
  input  wire logic [7:0] vin,
  output logic            done_n,
  output logic            rdy_low,
  output logic            bus_en,
  output logic [7:0]      bus_q
);
  logic [7:0] samp;
  logic       cs_q, rd_q, wr_q;
  int         cnt;
  initial begin
    {done_n, cs_q, rd_q, wr_q} = 4'hf;
    {rdy_low, cnt, samp, bus_q} = '0;
  end
  assign bus_en = !cs_n && !rd_n;
  always @(posedge sys_clk) begin
    cs_q <= cs_n;
    rd_q <= rd_n;
    wr_q <= pin;
    if (mode && !cs_n && wr_q && !pin) samp <= vin;
    if (mode && !wr_q && pin) cnt <= T_INT;
    if ((!cs_q && cs_n) || (!rd_q && rd_n)) done_n <= 1'b1;
    if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 1) begin
      bus_q <= samp;
      done_n <= 1'b0;
      rdy_low <= 1'b0;
    end
    if (!cs_n && rd_q && !rd_n && !mode) begin
      samp <= vin;
      rdy_low <= 1'b1;
      cnt <= T_RS;
    end
    if (!cs_n && rd_q && !rd_n && mode && cnt > 0) begin
      bus_q <= samp;
      done_n <= 1'b0;
      cnt <= 0;
    end
  end
endmodule

/* dv/sah_host_test.sv */
// bench for the sampling converter host port
// assumes sah_host in src/ and the converter model in dv/
`timescale 1ns/1ps
module sah_host_test;
  logic       sys_clk = 0, nrst = 0, start_req = 0, auto_en = 0;
  logic       split_sel = 0, fast_sel = 0, cs_d = 1;
  logic       conv_cs_n, conv_rd_n, strobe_out, strobe_oe_n, mode_pin;
  logic       result_valid, busy, done_n, rdy_low, bus_en;
  logic [7:0] result, bus_q, vin = 8'h00;
  int         err_count = 0, compares = 0, n, gap = 1000;
  // pull-up on the shared pin; released bus shows inverted data
  wire        pin = !strobe_oe_n ? strobe_out : !rdy_low;
  wire  [7:0] res_bus = bus_en ? bus_q : ~bus_q;
  always #2 sys_clk = ~sys_clk;
  sah_host #(.PERIOD_CYC(16'h0190)) sah_host_i (.sys_clk(sys_clk),
    .nrst(nrst), .start_req(start_req), .auto_en(auto_en),
    .split_sel(split_sel), .fast_sel(fast_sel), .conv_cs_n(conv_cs_n),
    .conv_rd_n(conv_rd_n), .strobe_out(strobe_out),
    .strobe_oe_n(strobe_oe_n), .strobe_in(pin), .done_n(done_n),
    .result_bus(res_bus), .mode_pin(mode_pin), .result(result),
    .result_valid(result_valid), .busy(busy));
  sah_dev_model sah_dev_model_i (.sys_clk(sys_clk), .cs_n(conv_cs_n),
    .rd_n(conv_rd_n), .pin(pin), .mode(mode_pin), .vin(vin),
    .done_n(done_n), .rdy_low(rdy_low), .bus_en(bus_en), .bus_q(bus_q));
  task automatic results();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tick(input int lim);
    @(posedge sys_clk);
    #1;
    n++;
    if (n > lim) begin
      err_count++;
      $display("BAD wait exp done got stuck");
      results();
    end
  endtask
  task automatic go(logic sel, logic fast, logic [7:0] code);
    @(posedge sys_clk);
    {split_sel, fast_sel, vin} <= {sel, fast, code};
    repeat (2) @(posedge sys_clk);
    start_req <= 1'b1;
    @(posedge sys_clk);
    start_req <= 1'b0;
    for (n = 0; conv_cs_n !== 1'b0; ) tick(500);
    chk("busy", 16'h0001, {15'h0, busy});
    repeat (3) @(posedge sys_clk);
    vin <= ~code;
    n = 0;
    do tick(3000); while (result_valid !== 1'b1);
    chk("result", {8'h00, code}, {8'h00, result});
    chk("busy_end", 16'h0000, {15'h0, busy});
    chk("mode_pin", {15'h0, sel}, {15'h0, mode_pin});
    chk("strobe_oe_n", {15'h0, !sel}, {15'h0, strobe_oe_n});
  endtask
  always @(posedge sys_clk) begin
    cs_d <= conv_cs_n;
    gap <= result_valid ? 0 : gap + 1;
    if (cs_d === 1'b1 && conv_cs_n === 1'b0) begin
      compares++;
      if (gap < 88) begin
        err_count++;
        $display("BAD gap exp 88 got %0d", gap);
      end
    end
  end
  task automatic t_rdstart();
    go(1'b0, 1'b0, 8'ha5);
    $display("test rdstart done");
  endtask
  task automatic t_split_norm();
    go(1'b1, 1'b0, 8'h3c);
    chk("slow", 16'h0001, {15'h0, n > 159});
    $display("test split normal done");
  endtask
  task automatic t_split_fast();
    go(1'b1, 1'b1, 8'hc3);
    chk("fast", 16'h0001, {15'h0, n < 159});
    go(1'b1, 1'b1, 8'h00);
    go(1'b1, 1'b1, 8'hff);
    $display("test split fast done");
  endtask
  task automatic t_auto();
    @(posedge sys_clk);
    auto_en <= 1'b1;
    n = 0;
    do tick(3000); while (result_valid !== 1'b1);
    n = 0;
    do tick(3000); while (result_valid !== 1'b1);
    chk("period", 16'h0190, n[15:0]);
    @(posedge sys_clk);
    auto_en <= 1'b0;
    $display("test auto done");
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    t_rdstart();
    t_split_norm();
    t_split_fast();
    t_auto();
    results();
  end
endmodule
